//--- inc/plc_pkg.sv
package plc_pkg;

    // management register addresses
    localparam logic [4:0] AUX_ADDR = 5'h12;
    localparam logic [4:0] LED_ADDR = 5'h13;
    localparam logic [4:0] STATUS_ADDR = 5'h11;

    // auxiliary control fields
    localparam int AUX_LOOP_BIT = 5;
    localparam int AUX_REVERSE_BIT = 4;
    localparam int AUX_JABBER_OFF_BIT = 0;
    localparam logic [15:0] AUX_WRITE_MASK = 16'h0031;
    localparam logic [15:0] AUX_RESET = 16'h0000;

    // status register bit that mirrors loopback
    localparam int STATUS_LOOP_BIT = 7;

    // indicator light control fields
    localparam int NUM_LEDS = 5;
    localparam int LED_TOP_LSB = 14;
    localparam int LED_ACT = 0;
    localparam int LED_L10 = 1;
    localparam int LED_L100 = 2;
    localparam int LED_L1000 = 3;
    localparam int LED_DUPLEX = 4;
    localparam int LED_REDUCED_BIT = 5;
    localparam int LED_IDLE_ERR_BIT = 3;
    localparam logic [15:0] LED_RESET = 16'h0000;

    // management frame constants
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [5:0] PREAMBLE_LEN = 6'h20;
    localparam logic [3:0] HDR_LAST = 4'hb;
    localparam logic [3:0] TURN_LAST = 4'h1;
    localparam logic [3:0] DATA_LAST = 4'hf;

    // blink timing
    localparam longint CLK_HZ = 40000000;
    localparam longint BLINK_PERIOD_MS = 750;
    localparam longint BLINK_HALF_CYCLES = CLK_HZ * BLINK_PERIOD_MS / 1000 / 2;

    typedef enum logic [1:0] {
        LED_NORMAL = 2'h0,
        LED_OFF = 2'h1,
        LED_BLINK = 2'h2,
        LED_ON = 2'h3
    } plc_led_mode_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_HEADER = 5'h04,
        ST_TURN = 5'h08,
        ST_DATA = 5'h10
    } plc_mgmt_state_t;

    typedef struct packed {
        logic en;
        logic er;
        logic [7:0] data;
    } plc_gmii_t;

endpackage

//--- src/plc_blink.sv
// free-running half-period counter; phase toggles at each wrap
module plc_blink #(
    parameter logic [31:0] HALF_CYCLES = 32'(plc_pkg::BLINK_HALF_CYCLES)
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    output logic phase_o
);
    logic [31:0] count;

    // count one half period, then flip the blink phase
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count <= 32'h0;
            phase_o <= 1'b0;
        end
        else if (count >= HALF_CYCLES - 32'h1)
        begin
            count <= 32'h0;
            phase_o <= ~phase_o;
        end
        else
        begin
            count <= count + 32'h1;
        end
    end
endmodule

//--- src/plc_led_drive.sv
// per-light mode decode, registered drive
module plc_led_drive (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [15:0] led_ctrl_i,
    input wire logic [plc_pkg::NUM_LEDS-1:0] status_i,
    input wire logic blink_i,
    output logic [plc_pkg::NUM_LEDS-1:0] led_o
);
    genvar i;
    generate
        for (i = 0; i < plc_pkg::NUM_LEDS; i++)
        begin : g_led
            localparam int LSB = plc_pkg::LED_TOP_LSB - 2 * i;
            plc_pkg::plc_led_mode_t mode;
            assign mode = plc_pkg::plc_led_mode_t'(led_ctrl_i[LSB+1:LSB]);
            // only the normal code follows device status
            always_ff @(posedge clk_i or negedge resetn_i)
            begin
                if (!resetn_i)
                    led_o[i] <= 1'b0;
                else
                begin
                    unique case (mode)
                        plc_pkg::LED_NORMAL: led_o[i] <= status_i[i];
                        plc_pkg::LED_OFF: led_o[i] <= 1'b0;
                        plc_pkg::LED_BLINK: led_o[i] <= blink_i;
                        plc_pkg::LED_ON: led_o[i] <= 1'b1;
                    endcase
                end
            end
        end
    endgenerate
endmodule

//--- src/plc_top.sv
module plc_top #(
    parameter logic [31:0] BLINK_HALF_CYCLES = 32'(plc_pkg::BLINK_HALF_CYCLES)
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic [4:0] phy_addr_i,
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    input wire plc_pkg::plc_gmii_t mac_tx_i,
    output plc_pkg::plc_gmii_t mac_rx_o,
    output plc_pkg::plc_gmii_t line_tx_o,
    input wire plc_pkg::plc_gmii_t line_rx_i,
    input wire logic speed_10_i,
    input wire logic jabber_detect_i,
    output logic jabber_o,
    output logic loopback_status_o,
    input wire logic link_10_i,
    input wire logic link_100_i,
    input wire logic link_1000_i,
    input wire logic full_duplex_i,
    input wire logic idle_error_i,
    input wire logic reduced_link_only_i,
    output logic [plc_pkg::NUM_LEDS-1:0] led_o
);

    logic [15:0] aux_ctrl;
    logic [15:0] led_ctrl;
    logic mdc_s1;
    logic mdc_s2;
    logic mdc_s3;
    logic mdio_s1;
    logic mdio_s2;
    logic mdc_rise;
    plc_pkg::plc_mgmt_state_t state;
    logic [5:0] pre_cnt;
    logic [3:0] bit_cnt;
    logic [11:0] header;
    logic [15:0] wr_shift;
    logic [15:0] rd_shift;
    logic [15:0] wr_word;
    logic wr_stb;
    logic [4:0] reg_addr;
    logic owned;
    logic sel_read;
    logic sel_write;
    logic [15:0] rdata;
    logic loop_en;
    logic reverse_en;
    logic [7:0] tx_rev;
    logic [7:0] rx_rev;
    logic [7:0] tx_bits;
    logic [7:0] rx_bits;
    logic activity;
    logic link_any;
    logic combined;
    logic blink;
    logic [plc_pkg::NUM_LEDS-1:0] led_status;

    // two-stage synchronisers for the management pins
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mdc_s1 <= 1'b1; // parked-high clock gives no false rise
            mdc_s2 <= 1'b1;
            mdc_s3 <= 1'b1;
            mdio_s1 <= 1'b1;
            mdio_s2 <= 1'b1;
        end
        else
        begin
            mdc_s1 <= mdc_i;
            mdc_s2 <= mdc_s1;
            mdc_s3 <= mdc_s2;
            mdio_s1 <= mdio_i;
            mdio_s2 <= mdio_s1;
        end
    end

    // management clock rising edge, seen after synchronisation
    assign mdc_rise = mdc_s2 & ~mdc_s3;

    // frame header decode, stable from turnaround onward
    assign reg_addr = header[4:0];
    assign owned = (reg_addr == plc_pkg::AUX_ADDR) || (reg_addr == plc_pkg::LED_ADDR);
    assign sel_read = (header[11:10] == plc_pkg::OP_READ) && (header[9:5] == phy_addr_i) && owned;
    assign sel_write = (header[11:10] == plc_pkg::OP_WRITE) && (header[9:5] == phy_addr_i) && owned;

    // frame sequencer: preamble, start, header, turnaround, data
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= plc_pkg::ST_IDLE;
            pre_cnt <= 6'h0;
            bit_cnt <= 4'h0;
            header <= 12'h0;
            wr_shift <= 16'h0;
        end
        else if (mdc_rise)
        begin
            unique case (state)
                plc_pkg::ST_IDLE:
                begin
                    if (mdio_s2)
                    begin
                        if (pre_cnt != plc_pkg::PREAMBLE_LEN)
                            pre_cnt <= pre_cnt + 6'h1;
                    end
                    else if (pre_cnt == plc_pkg::PREAMBLE_LEN)
                    begin
                        state <= plc_pkg::ST_START;
                        pre_cnt <= 6'h0;
                    end
                    else
                    begin
                        pre_cnt <= 6'h0;
                    end
                end
                plc_pkg::ST_START:
                begin
                    bit_cnt <= 4'h0;
                    if (mdio_s2)
                        state <= plc_pkg::ST_HEADER;
                    else
                        state <= plc_pkg::ST_IDLE;
                end
                plc_pkg::ST_HEADER:
                begin
                    header <= {header[10:0], mdio_s2};
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == plc_pkg::HDR_LAST)
                    begin
                        state <= plc_pkg::ST_TURN;
                        bit_cnt <= 4'h0;
                    end
                end
                plc_pkg::ST_TURN:
                begin
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == plc_pkg::TURN_LAST)
                    begin
                        state <= plc_pkg::ST_DATA;
                        bit_cnt <= 4'h0;
                    end
                end
                plc_pkg::ST_DATA:
                begin
                    wr_shift <= {wr_shift[14:0], mdio_s2};
                    bit_cnt <= bit_cnt + 4'h1;
                    if (bit_cnt == plc_pkg::DATA_LAST)
                    begin
                        state <= plc_pkg::ST_IDLE;
                        bit_cnt <= 4'h0;
                    end
                end
            endcase
        end
    end

    // write strobe and word at the last data bit of a write frame
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wr_stb <= 1'b0;
            wr_word <= 16'h0;
        end
        else
        begin
            wr_stb <= mdc_rise && (state == plc_pkg::ST_DATA)
                && (bit_cnt == plc_pkg::DATA_LAST) && sel_write;
            if (mdc_rise && (state == plc_pkg::ST_DATA))
                wr_word <= {wr_shift[14:0], mdio_s2};
        end
    end

    // read data drive: release, turnaround zero, then sixteen bits msb first
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mdio_o <= 1'b0;
            mdio_oe_o <= 1'b0;
            rd_shift <= 16'h0;
        end
        else if (mdc_rise)
        begin
            if ((state == plc_pkg::ST_TURN) && sel_read && (bit_cnt == 4'h0))
            begin
                mdio_oe_o <= 1'b1;
                mdio_o <= 1'b0;
            end
            else if ((state == plc_pkg::ST_TURN) && sel_read)
            begin
                mdio_o <= rdata[15];
                rd_shift <= {rdata[14:0], 1'b0};
            end
            else if ((state == plc_pkg::ST_DATA) && sel_read
                && (bit_cnt != plc_pkg::DATA_LAST))
            begin
                mdio_o <= rd_shift[15];
                rd_shift <= {rd_shift[14:0], 1'b0};
            end
            else
            begin
                mdio_oe_o <= 1'b0;
                mdio_o <= 1'b0;
            end
        end
    end

    // register read mux
    always_comb
    begin
        if (reg_addr == plc_pkg::AUX_ADDR)
            rdata = aux_ctrl & plc_pkg::AUX_WRITE_MASK;
        else if (reg_addr == plc_pkg::LED_ADDR)
            rdata = led_ctrl;
        else
            rdata = 16'h0;
    end

    // auxiliary control: only loopback, reverse and jabber bits hold state
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            aux_ctrl <= plc_pkg::AUX_RESET;
        else if (wr_stb && (reg_addr == plc_pkg::AUX_ADDR))
            aux_ctrl <= wr_word & plc_pkg::AUX_WRITE_MASK;
    end

    // indicator light control, all sixteen bits stored
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            led_ctrl <= plc_pkg::LED_RESET;
        else if (wr_stb && (reg_addr == plc_pkg::LED_ADDR))
            led_ctrl <= wr_word;
    end

    assign loop_en = aux_ctrl[plc_pkg::AUX_LOOP_BIT];
    assign reverse_en = aux_ctrl[plc_pkg::AUX_REVERSE_BIT];
    assign loopback_status_o = loop_en;

    // bit-reversed copies of both data bytes
    genvar b;
    generate
        for (b = 0; b < 8; b++)
        begin : g_rev
            assign tx_rev[b] = mac_tx_i.data[7-b];
            assign rx_rev[b] = line_rx_i.data[7-b];
        end
    endgenerate

    assign tx_bits = reverse_en ? tx_rev : mac_tx_i.data;
    assign rx_bits = reverse_en ? rx_rev : line_rx_i.data;

    // receive path toward the MAC, looped from transmit when enabled
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            mac_rx_o <= '0;
        else if (loop_en)
            mac_rx_o <= mac_tx_i;
        else
            mac_rx_o <= '{en: line_rx_i.en, er: line_rx_i.er, data: rx_bits};
    end

    // transmit path toward the line, silent during loopback
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            line_tx_o <= '0;
        else if (loop_en)
            line_tx_o <= '0;
        else
            line_tx_o <= '{en: mac_tx_i.en, er: mac_tx_i.er, data: tx_bits};
    end

    // jabber suppression at 10 Mb/s
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            jabber_o <= 1'b0;
        else
            jabber_o <= jabber_detect_i
                & ~(aux_ctrl[plc_pkg::AUX_JABBER_OFF_BIT] & speed_10_i);
    end

    // device status that each light shows in normal mode
    assign activity = mac_tx_i.en | line_rx_i.en
        | (idle_error_i & led_ctrl[plc_pkg::LED_IDLE_ERR_BIT]);
    assign link_any = link_10_i | link_100_i | link_1000_i;
    assign combined = reduced_link_only_i ? link_any
        : (link_any & (activity ? blink : 1'b1));

    always_comb
    begin
        led_status = '0;
        led_status[plc_pkg::LED_ACT] = activity;
        led_status[plc_pkg::LED_L10] = led_ctrl[plc_pkg::LED_REDUCED_BIT]
            ? combined : link_10_i;
        led_status[plc_pkg::LED_L100] = link_100_i;
        led_status[plc_pkg::LED_L1000] = link_1000_i;
        led_status[plc_pkg::LED_DUPLEX] = link_any & full_duplex_i;
    end

    // shared blink phase
    plc_blink #(
        .HALF_CYCLES(BLINK_HALF_CYCLES)
    ) u_blink (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .phase_o(blink)
    );

    // mode decode and registered light outputs
    plc_led_drive u_led (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .led_ctrl_i(led_ctrl),
        .status_i(led_status),
        .blink_i(blink),
        .led_o(led_o)
    );

endmodule

//--- test/plc_properties.sv
// port-level checks on the datapath and jabber path
module plc_checker #(
    parameter logic [31:0] BLINK_HALF_CYCLES = 32'(plc_pkg::BLINK_HALF_CYCLES)
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire plc_pkg::plc_gmii_t mac_tx_i,
    input wire plc_pkg::plc_gmii_t mac_rx_o,
    input wire plc_pkg::plc_gmii_t line_tx_o,
    input wire plc_pkg::plc_gmii_t line_rx_i,
    input wire logic speed_10_i,
    input wire logic jabber_detect_i,
    input wire logic jabber_o,
    input wire logic loopback_status_o
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // bit order swap of one byte
    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int b = 0; b < 8; b++)
        begin
            rev8[b] = d[7-b];
        end
    endfunction

    // loopback echoes transmit one cycle later and mutes the line
    property p_loop_echo;
        $past(loopback_status_o) |-> mac_rx_o == $past(mac_tx_i);
    endproperty
    a_loop_echo: assert property (p_loop_echo) else $error("loop echo wrong");
    property p_loop_mute;
        loopback_status_o && $past(loopback_status_o) |-> line_tx_o == '0;
    endproperty
    a_loop_mute: assert property (p_loop_mute) else $error("line not muted");

    // normal path keeps rx framing bits and tx enable, and allows only straight or swapped data
    property p_rx_ctl;
        !$past(loopback_status_o) |-> {mac_rx_o.en, mac_rx_o.er} == $past({line_rx_i.en,
            line_rx_i.er});
    endproperty
    a_rx_ctl: assert property (p_rx_ctl) else $error("rx framing wrong");
    property p_tx_ctl;
        !$past(loopback_status_o) |-> line_tx_o.en == $past(mac_tx_i.en);
    endproperty
    a_tx_ctl: assert property (p_tx_ctl) else $error("tx enable wrong");
    property p_rx_order;
        !$past(loopback_status_o) |-> mac_rx_o.data == $past(line_rx_i.data)
            || mac_rx_o.data == rev8($past(line_rx_i.data));
    endproperty
    a_rx_order: assert property (p_rx_order) else $error("rx data order wrong");
    property p_tx_order;
        !$past(loopback_status_o) |-> line_tx_o.data == $past(mac_tx_i.data)
            || line_tx_o.data == rev8($past(mac_tx_i.data));
    endproperty
    a_tx_order: assert property (p_tx_order) else $error("tx data order wrong");

    // jabber suppression acts only at 10 Mb/s
    property p_jab_fast;
        !$past(speed_10_i) |-> jabber_o == $past(jabber_detect_i);
    endproperty
    a_jab_fast: assert property (p_jab_fast) else $error("jabber lost");
    property p_jab_quiet;
        !$past(jabber_detect_i) |-> !jabber_o;
    endproperty
    a_jab_quiet: assert property (p_jab_quiet) else $error("false jabber");

    // main scenarios reached
    c_loop: cover property (loopback_status_o && mac_tx_i.en);
    c_swap: cover property (mac_rx_o.data != $past(line_rx_i.data));
    c_jab_off: cover property (speed_10_i && jabber_detect_i ##1 !jabber_o);
endmodule

bind plc_top plc_checker #(.BLINK_HALF_CYCLES(BLINK_HALF_CYCLES)) u_plc_checker (
    .clk_i(clk_i), .resetn_i(resetn_i), .mac_tx_i(mac_tx_i), .mac_rx_o(mac_rx_o),
    .line_tx_o(line_tx_o), .line_rx_i(line_rx_i), .speed_10_i(speed_10_i),
    .jabber_detect_i(jabber_detect_i), .jabber_o(jabber_o),
    .loopback_status_o(loopback_status_o)
);

//--- test/plc_host_model.sv
// management host: full-preamble frames, 16 clk per management bit
module plc_host_model (
    input wire logic clk_i,
    input wire logic mdio_i,
    output logic mdc_o,
    output logic mdio_o,
    output logic mdio_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus: clock parked, line released to its pull-up
    initial
    begin
        mdc_o = 1'b1;
        mdio_o = 1'b1;
        mdio_oe_o = 1'b0;
    end

    // one bit: data set while the clock is low, sampled at the rise
    task automatic bit_cycle(input logic d, input logic drv, output logic q);
        mdc_o = 1'b0;
        mdio_o = d;
        mdio_oe_o = drv;
        repeat (8) @(negedge clk_i);
        mdc_o = 1'b1;
        q = mdio_i;
        repeat (8) @(negedge clk_i);
    endtask

    // rd returns turnaround second bit followed by the data word
    task automatic frame(input logic [1:0] op, input logic [4:0] ph, input logic [4:0] a,
                         input logic [15:0] wd, output logic [16:0] rd);
        logic [63:0] f;
        logic q;
        f = {32'hffffffff, 2'h1, op, ph, a, 2'h2, wd};
        rd = '0;
        for (int i = 63; i >= 0; i--)
        begin
            bit_cycle(f[i], !(op == plc_pkg::OP_READ && i < 18), q);
            rd = {rd[15:0], q};
        end
        mdio_oe_o = 1'b0;
    endtask
endmodule

//--- test/tb_phy_aux_and_led_control.sv
module tb_phy_aux_and_led_control;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] PHY = 5'h05;
    localparam logic [4:0] AUX = plc_pkg::AUX_ADDR;
    localparam logic [4:0] LED = plc_pkg::LED_ADDR;
    localparam logic [1:0] W = plc_pkg::OP_WRITE;
    localparam logic [1:0] R = plc_pkg::OP_READ;
    localparam int HALF = 4;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    plc_pkg::plc_gmii_t mac_tx = '0;
    plc_pkg::plc_gmii_t line_rx = '0;
    plc_pkg::plc_gmii_t mac_rx, line_tx, e_rx, e_tx;
    logic sp10 = 0, jab = 0, l10 = 0, l100 = 0, l1k = 0, fdx = 0, idle = 0, lonly = 0;
    logic mdc, h_d, h_oe, d_d, d_oe, jab_o, loop_o, e_jab;
    logic [4:0] led_o, e_led;
    logic [15:0] aux = 16'h0000;
    logic [15:0] led = 16'h0000;
    logic [15:0] av [5] = '{16'h0020, 16'h0010, 16'h0001, 16'h0031, 16'h0000};
    logic [16:0] rd;
    wire mdio = d_oe ? d_d : (h_oe ? h_d : 1'b1);
    integer seed = 52706;
    integer n_fail = 0;
    integer check_count = 0;
    integer edges = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    // clock edges since reset release, for the blink phase model
    always @(posedge clk)
    begin
        if (resetn)
            edges <= edges + 1;
    end

    plc_top #(.BLINK_HALF_CYCLES(32'(HALF))) u_plc_top (
        .clk_i(clk), .resetn_i(resetn), .phy_addr_i(PHY), .mdc_i(mdc), .mdio_i(mdio),
        .mdio_o(d_d), .mdio_oe_o(d_oe), .mac_tx_i(mac_tx), .mac_rx_o(mac_rx),
        .line_tx_o(line_tx), .line_rx_i(line_rx), .speed_10_i(sp10),
        .jabber_detect_i(jab), .jabber_o(jab_o), .loopback_status_o(loop_o),
        .link_10_i(l10), .link_100_i(l100), .link_1000_i(l1k), .full_duplex_i(fdx),
        .idle_error_i(idle), .reduced_link_only_i(lonly), .led_o(led_o)
    );
    plc_host_model u_plc_host_model (
        .clk_i(clk), .mdio_i(mdio), .mdc_o(mdc), .mdio_o(h_d), .mdio_oe_o(h_oe)
    );

    function automatic logic [7:0] rev8(input logic [7:0] d);
        for (int b = 0; b < 8; b++)
        begin
            rev8[b] = d[7-b];
        end
    endfunction

    task automatic cmp(input string n, input logic [16:0] e, input logic [16:0] g);
        check_count++;
        if (g !== e)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic conclude();
        if (n_fail == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // random traffic and status; model predicts the datapath, jabber, loopback status and light outputs
    task automatic run(input int n);
        logic [1:0] m;
        logic act, any, bl, comb;
        logic [4:0] st;
        for (int i = 0; i <= n; i++)
        begin
            @(negedge clk);
            if (i > 0)
            begin
                cmp("mac_rx", {7'h0, e_rx}, {7'h0, mac_rx});
                cmp("line_tx", {7'h0, e_tx}, {7'h0, line_tx});
                cmp("jabber", {16'h0, e_jab}, {16'h0, jab_o});
                cmp("loop_status", {16'h0, aux[5]}, {16'h0, loop_o});
                cmp("led", {12'h0, e_led}, {12'h0, led_o});
            end
            {mac_tx, line_rx, sp10, jab, l10, l100, l1k, fdx, idle, lonly} = 28'($random(seed));
            e_rx = aux[5] ? mac_tx : line_rx;
            e_tx = aux[5] ? '0 : mac_tx;
            if (aux[4] && !aux[5])
            begin
                e_rx.data = rev8(line_rx.data);
                e_tx.data = rev8(mac_tx.data);
            end
            e_jab = jab & !(sp10 & aux[0]);
            act = mac_tx.en | line_rx.en | (idle & led[3]);
            any = l10 | l100 | l1k;
            bl = 1'((edges / HALF) % 2);
            comb = lonly ? any : (any & (!act | bl));
            st = {any & fdx, l1k, l100, led[5] ? comb : l10, act};
            for (int k = 0; k < 5; k++)
            begin
                m = led[15-2*k -: 2];
                e_led[k] = (m == 2'h0) ? st[k] : m[1];
                if (m == 2'h2)
                begin
                    e_led[k] = bl;
                end
            end
        end
    endtask

    // blink phase must toggle every half period whatever the status
    task automatic blink_cnt();
        integer c;
        logic p;
        c = 0;
        @(negedge clk);
        p = led_o[0];
        repeat (80)
        begin
            @(negedge clk);
            c += (led_o[0] !== p);
            p = led_o[0];
        end
        cmp("blink", 17'h1, 17'(c >= 19 && c <= 21));
    endtask

    // main sequence
    initial
    begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        cmp("led reset", 17'h0, {12'h0, led_o});
        u_plc_host_model.frame(R, PHY, AUX, 16'h0, rd);
        cmp("aux reset", 17'h0, rd);
        u_plc_host_model.frame(R, PHY, LED, 16'h0, rd);
        cmp("led reg reset", 17'h0, rd);
        for (int i = 0; i < 5; i++)
        begin
            aux = av[i];
            u_plc_host_model.frame(W, PHY, AUX, aux, rd);
            u_plc_host_model.frame(R, PHY, AUX, 16'h0, rd);
            cmp("aux read", {1'b0, aux}, rd);
            run(60);
        end
        for (int j = 0; j < 4; j++)
        begin
            led = {{5{2'(j)}}, 1'b0, 5'($random(seed))};
            u_plc_host_model.frame(W, PHY, LED, led, rd);
            u_plc_host_model.frame(R, PHY, LED, 16'h0, rd);
            cmp("led read", {1'b0, led}, rd);
            run(60);
        end
        led = 16'h0028;
        u_plc_host_model.frame(W, PHY, LED, led, rd);
        run(200);
        led = 16'haa80;
        u_plc_host_model.frame(W, PHY, LED, led, rd);
        blink_cnt();
        u_plc_host_model.frame(W, 5'h06, AUX, 16'h0031, rd);
        u_plc_host_model.frame(R, PHY, AUX, 16'h0, rd);
        cmp("foreign write", 17'h0, rd);
        u_plc_host_model.frame(R, 5'h06, AUX, 16'h0, rd);
        cmp("foreign read", 17'h1ffff, rd);
        u_plc_host_model.frame(R, PHY, 5'h14, 16'h0, rd);
        cmp("unmapped read", 17'h1ffff, rd);
        conclude();
    end

    // hang guard, about twice the expected run
    initial
    begin
        #1500000;
        n_fail++;
        conclude();
    end
endmodule
